// ==== tws_pkg.sv ====
// Shared constants and types for the two-wire bus slave.
`default_nettype none
package tws_pkg;
    // ************************************************************
    // Register port and register map.
    // ************************************************************
    localparam int REG_AW = 3;
    localparam int REG_DW = 16;
    localparam int ADDR_W = 10;
    localparam int BRG_W = 9;
    localparam logic [REG_AW-1:0] OFS_CTL = 3'h0;
    localparam logic [REG_AW-1:0] OFS_STAT = 3'h1;
    localparam logic [REG_AW-1:0] OFS_ADDR = 3'h2;
    localparam logic [REG_AW-1:0] OFS_RCV = 3'h3;
    localparam logic [REG_AW-1:0] OFS_TRN = 3'h4;
    localparam logic [REG_AW-1:0] OFS_BRG = 3'h5;
    // ************************************************************
    // Control and status bit positions and reset values.
    // ************************************************************
    localparam int CTL_EN = 15;
    localparam int CTL_REL = 12;
    localparam int CTL_A10 = 10;
    localparam int STB_TBF = 0;
    localparam int STB_RBF = 1;
    localparam int STB_RW = 2;
    localparam int STB_START = 3;
    localparam int STB_STOP = 4;
    localparam int STB_DNA = 5;
    localparam int STB_OV = 6;
    localparam int STB_FULL_TEN_BIT_MATCH_FLAG = 8;
    localparam int STB_EVT = 9;
    localparam logic [REG_DW-1:0] CTL_RST = 16'h1000;
    // ************************************************************
    // Bit counts and address pattern.
    // ************************************************************
    localparam logic [4:0] TEN_PREFIX = 5'h1e;
    localparam logic [3:0] BYTE_LAST = 4'h7;
    localparam logic [3:0] BYTE_BITS = 4'h8;
    localparam logic [3:0] ACK_CLK = 4'h9;
    typedef enum logic [2:0] {
        S_IDLE,
        S_ADDR,
        S_ADDR2,
        S_RX,
        S_TX,
        S_IGNORE
    } tws_state_t;
endpackage : tws_pkg
`default_nettype wire

// ==== tws_line_if.sv ====
// Bus line events passed from the pin sensing logic to the slave core.
`timescale 1ns/1ns
`default_nettype none
interface tws_line_if;
    logic scl_rise;
    logic scl_fall;
    logic start;
    logic stop;
    logic sda_lvl;
    modport sense (output scl_rise, output scl_fall, output start, output stop, output sda_lvl);
    modport core (input scl_rise, input scl_fall, input start, input stop, input sda_lvl);
endinterface : tws_line_if
`default_nettype wire

// ==== tws_line_sense.sv ====
// Pin synchronisers with clock edge, Start and Stop detection.
`timescale 1ns/1ns
`default_nettype none
module tws_line_sense
    import tws_pkg::*;
(
    input wire logic mclk,
    input wire logic reset,
    input wire logic scl_in,
    input wire logic sda_in,
    tws_line_if.sense ln
);
    typedef struct packed {
        logic scl_s1;
        logic scl_s2;
        logic sda_s1;
        logic sda_s2;
        logic scl_d;
        logic sda_d;
        logic rise;
        logic fall;
        logic start;
        logic stop;
        logic sda_lvl;
    } tws_sense_t;

    tws_sense_t r;
    tws_sense_t n;

    always_comb begin
        n = r;
        n.scl_s1 = scl_in;
        n.scl_s2 = r.scl_s1;
        n.sda_s1 = sda_in;
        n.sda_s2 = r.sda_s1;
        n.scl_d = r.scl_s2;
        n.sda_d = r.sda_s2;
        n.rise = r.scl_s2 & ~r.scl_d;
        n.fall = ~r.scl_s2 & r.scl_d;
        n.start = r.scl_s2 & r.scl_d & r.sda_d & ~r.sda_s2;
        n.stop = r.scl_s2 & r.scl_d & ~r.sda_d & r.sda_s2;
        n.sda_lvl = r.sda_s2;
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            // Idle bus lines are high, so reset to that level and no false edge follows reset.
            r <= '0;
            r.scl_s1 <= 1'b1;
            r.scl_s2 <= 1'b1;
            r.sda_s1 <= 1'b1;
            r.sda_s2 <= 1'b1;
            r.scl_d <= 1'b1;
            r.sda_d <= 1'b1;
            r.sda_lvl <= 1'b1;
        end else begin
            r <= n;
        end
    end

    assign ln.scl_rise = r.rise;
    assign ln.scl_fall = r.fall;
    assign ln.start = r.start;
    assign ln.stop = r.stop;
    assign ln.sda_lvl = r.sda_lvl;
endmodule : tws_line_sense
`default_nettype wire

// ==== tws_baud.sv ====
// Reload counter that times the data hold after a falling clock edge.
`timescale 1ns/1ns
`default_nettype none
module tws_baud
    import tws_pkg::*;
(
    input wire logic mclk,
    input wire logic reset,
    input wire logic [BRG_W-1:0] reload,
    input wire logic arm,
    output logic done
);
    typedef struct packed {
        logic [BRG_W-1:0] cnt;
        logic busy;
        logic done;
    } tws_baud_t;

    tws_baud_t r;
    tws_baud_t n;

    always_comb begin
        n = r;
        n.done = 1'b0;
        if (arm) begin
            n.cnt = reload;
            n.busy = 1'b1;
        end else if (r.busy) begin
            if (r.cnt == '0) begin
                n.busy = 1'b0;
                n.done = 1'b1;
            end else begin
                n.cnt = r.cnt - 9'h1;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    assign done = r.done;
endmodule : tws_baud
`default_nettype wire

// ==== tws_slave.sv ====
// Two-wire bus slave: address match, double-buffered receive, held transmit.
//
// Our own choices: the address map and strobed register access.
`timescale 1ns/1ns
`default_nettype none
module tws_slave
    import tws_pkg::*;
(
    input wire logic mclk,
    input wire logic reset,
    input wire logic [REG_AW-1:0] reg_addr,
    input wire logic [REG_DW-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [REG_DW-1:0] reg_rdata,
    input wire logic scl_in,
    output logic scl_out,
    output logic scl_oe,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    output logic slave_event
);
    // ************************************************************
    // State.
    // ************************************************************
    typedef struct packed {
        tws_state_t st;
        tws_state_t nx;
        logic [3:0] cnt;
        logic [7:0] shift;
        logic ack;
        logic rw;
        logic mack;
        logic loaded;
        logic sda_oe;
        logic sda_pend;
        logic sda_nv;
        logic scl_oe;
        logic pin_lo;
        logic [REG_DW-1:0] ctl;
        logic [ADDR_W-1:0] addr;
        logic [BRG_W-1:0] brg;
        logic [7:0] rcv;
        logic [7:0] trn;
        logic tbf;
        logic receive_full_flag;
        logic ov;
        logic full_ten_bit_match_flag;
        logic evt;
        logic strt;
        logic stp;
        logic dna;
        logic irq;
        logic [REG_DW-1:0] rdata;
    } tws_core_t;

    tws_core_t r;
    tws_core_t n;
    logic sda_req;
    logic sda_val;
    logic bg_done;
    logic [7:0] nb;
    logic [REG_DW-1:0] stat_word;

    tws_line_if ln ();

    tws_line_sense u_sense (
        .mclk(mclk),
        .reset(reset),
        .scl_in(scl_in),
        .sda_in(sda_in),
        .ln(ln.sense)
    );

    tws_baud u_baud (
        .mclk(mclk),
        .reset(reset),
        .reload(r.brg),
        .arm(sda_req),
        .done(bg_done)
    );

    always_comb begin
        stat_word = '0;
        stat_word[STB_TBF] = r.tbf;
        stat_word[STB_RBF] = r.receive_full_flag;
        stat_word[STB_RW] = r.rw;
        stat_word[STB_START] = r.strt;
        stat_word[STB_STOP] = r.stp;
        stat_word[STB_DNA] = r.dna;
        stat_word[STB_OV] = r.ov;
        stat_word[STB_FULL_TEN_BIT_MATCH_FLAG] = r.full_ten_bit_match_flag;
        stat_word[STB_EVT] = r.evt;
    end

    // ************************************************************
    // Next state.
    // ************************************************************
    always_comb begin
        n = r;
        sda_req = 1'b0;
        sda_val = 1'b0;
        nb = {r.shift[6:0], ln.sda_lvl};
        n.irq = 1'b0;
        n.rdata = '0;
        if (reg_wr) begin
            case (reg_addr)
                OFS_CTL: n.ctl = reg_wdata;
                OFS_STAT: begin
                    n.ov = reg_wdata[STB_OV];
                    n.full_ten_bit_match_flag = reg_wdata[STB_FULL_TEN_BIT_MATCH_FLAG];
                    n.evt = reg_wdata[STB_EVT];
                end
                OFS_ADDR: n.addr = reg_wdata[ADDR_W-1:0];
                OFS_TRN: begin
                    n.trn = reg_wdata[7:0];
                    n.tbf = 1'b1;
                end
                OFS_BRG: n.brg = reg_wdata[BRG_W-1:0];
                default: n.rdata = '0;
            endcase
        end
        if (reg_rd) begin
            case (reg_addr)
                OFS_CTL: n.rdata = r.ctl;
                OFS_STAT: n.rdata = stat_word;
                OFS_ADDR: n.rdata = {6'h00, r.addr};
                OFS_RCV: begin
                    n.rdata = {8'h00, r.rcv};
                    n.receive_full_flag = 1'b0;
                end
                OFS_TRN: n.rdata = {8'h00, r.trn};
                OFS_BRG: n.rdata = {7'h00, r.brg};
                default: n.rdata = '0;
            endcase
        end
        if (r.ctl[CTL_REL]) begin
            n.scl_oe = 1'b0;
        end
        if (bg_done && r.sda_pend) begin
            n.sda_oe = r.sda_nv;
            n.sda_pend = 1'b0;
        end
        if (!r.ctl[CTL_EN]) begin
            n.st = S_IDLE;
            n.sda_oe = 1'b0;
            n.sda_pend = 1'b0;
            n.scl_oe = 1'b0;
            n.loaded = 1'b0;
        end else if (ln.start) begin
            n.st = S_ADDR;
            n.cnt = '0;
            n.sda_oe = 1'b0;
            n.sda_pend = 1'b0;
            n.loaded = 1'b0;
            n.strt = 1'b1;
            n.stp = 1'b0;
        end else if (ln.stop) begin
            n.st = S_IDLE;
            n.sda_oe = 1'b0;
            n.sda_pend = 1'b0;
            n.scl_oe = 1'b0;
            n.loaded = 1'b0;
            n.full_ten_bit_match_flag = 1'b0;
            n.stp = 1'b1;
            n.strt = 1'b0;
        end else begin
            case (r.st)
                S_ADDR, S_ADDR2, S_RX: begin
                    if (ln.scl_rise) begin
                        n.cnt = r.cnt + 4'h1;
                        if (r.cnt < BYTE_BITS) begin
                            n.shift = nb;
                        end
                    end
                    if (ln.scl_rise && r.cnt == BYTE_LAST) begin
                        if (r.st == S_ADDR) begin
                            n.dna = 1'b0;
                            n.ack = 1'b0;
                            if (!r.ctl[CTL_A10]) begin
                                if (nb[7:1] == r.addr[6:0]) begin
                                    n.ack = 1'b1;
                                    n.rw = nb[0];
                                    n.nx = nb[0] ? S_TX : S_RX;
                                end else begin
                                    n.st = S_IGNORE;
                                end
                            end else if (nb[7:3] == TEN_PREFIX && nb[2:1] == r.addr[9:8]) begin
                                if (!nb[0]) begin
                                    n.ack = 1'b1;
                                    n.rw = 1'b0;
                                    n.full_ten_bit_match_flag = 1'b0;
                                    n.nx = S_ADDR2;
                                end else if (r.full_ten_bit_match_flag) begin
                                    n.ack = 1'b1;
                                    n.rw = 1'b1;
                                    n.nx = S_TX;
                                end else begin
                                    n.full_ten_bit_match_flag = 1'b0;
                                    n.st = S_IGNORE;
                                end
                            end else begin
                                n.full_ten_bit_match_flag = 1'b0;
                                n.st = S_IGNORE;
                            end
                        end else if (r.st == S_ADDR2) begin
                            if (nb == r.addr[7:0]) begin
                                n.ack = 1'b1;
                                n.full_ten_bit_match_flag = 1'b1;
                                n.nx = S_RX;
                            end else begin
                                n.ack = 1'b0;
                                n.full_ten_bit_match_flag = 1'b0;
                                n.st = S_IGNORE;
                            end
                        end else begin
                            n.dna = 1'b1;
                            n.nx = S_RX;
                            if (r.receive_full_flag) begin
                                n.ack = 1'b0;
                                n.ov = 1'b1;
                            end else if (r.ov) begin
                                n.rcv = nb;
                                n.receive_full_flag = 1'b1;
                                n.ack = 1'b0;
                            end else begin
                                n.rcv = nb;
                                n.receive_full_flag = 1'b1;
                                n.ack = 1'b1;
                            end
                        end
                    end
                    if (ln.scl_fall && r.cnt == BYTE_BITS) begin
                        sda_req = 1'b1;
                        sda_val = r.ack;
                    end
                    if (ln.scl_fall && r.cnt == ACK_CLK) begin
                        sda_req = 1'b1;
                        sda_val = 1'b0;
                        n.irq = 1'b1;
                        n.evt = 1'b1;
                        n.cnt = '0;
                        n.st = r.nx;
                        if (r.nx == S_TX) begin
                            n.scl_oe = 1'b1;
                            n.ctl[CTL_REL] = 1'b0;
                            n.loaded = 1'b0;
                        end
                    end
                end
                S_TX: begin
                    if (!r.loaded && r.tbf) begin
                        n.shift = r.trn;
                        n.tbf = 1'b0;
                        n.loaded = 1'b1;
                        n.cnt = '0;
                        sda_req = 1'b1;
                        sda_val = ~r.trn[7];
                    end
                    if (ln.scl_rise && r.loaded) begin
                        n.cnt = r.cnt + 4'h1;
                        if (r.cnt == BYTE_BITS) begin
                            n.mack = ~ln.sda_lvl;
                        end
                    end
                    if (ln.scl_fall && r.loaded) begin
                        if (r.cnt < BYTE_BITS) begin
                            n.shift = {r.shift[6:0], 1'b0};
                            sda_req = 1'b1;
                            sda_val = ~r.shift[6];
                        end else if (r.cnt == BYTE_BITS) begin
                            sda_req = 1'b1;
                            sda_val = 1'b0;
                        end else begin
                            n.irq = 1'b1;
                            n.evt = 1'b1;
                            n.loaded = 1'b0;
                            n.cnt = '0;
                            if (!r.mack) begin
                                n.st = S_IGNORE;
                            end else if (!r.tbf) begin
                                n.ctl[CTL_REL] = 1'b0;
                                n.scl_oe = 1'b1;
                            end
                        end
                    end
                end
                S_IDLE, S_IGNORE: begin
                    n.cnt = r.cnt;
                end
                default: n.st = S_IDLE;
            endcase
        end
        if (reg_wr && reg_addr == OFS_CTL && reg_wdata[CTL_REL]) begin
            n.ctl[CTL_REL] = 1'b1;
        end
        if (sda_req) begin
            n.sda_pend = 1'b1;
            n.sda_nv = sda_val;
        end
    end

    // ************************************************************
    // Registers and outputs.
    // ************************************************************
    always_ff @(posedge mclk) begin
        if (reset) begin
            r <= '0;
            r.ctl <= CTL_RST;
        end else begin
            r <= n;
        end
    end

    assign reg_rdata = r.rdata;
    assign scl_out = r.pin_lo;
    assign scl_oe = r.scl_oe;
    assign sda_out = r.pin_lo;
    assign sda_oe = r.sda_oe;
    assign slave_event = r.irq;
endmodule : tws_slave
`default_nettype wire

// ==== tws_properties.sv ====
// Concurrent checks on the ports of the two-wire bus slave.
`timescale 1ns/1ns
`default_nettype none
module tws_slave_properties
    import tws_pkg::*;
(
    input wire logic mclk,
    input wire logic reset,
    input wire logic [REG_AW-1:0] reg_addr,
    input wire logic [REG_DW-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [REG_DW-1:0] reg_rdata,
    input wire logic scl_in,
    input wire logic scl_out,
    input wire logic scl_oe,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe,
    input wire logic slave_event
);
    // ************************************************************
    // Helper terms and sequences.
    // ************************************************************
    logic free_wr;
    assign free_wr = reg_wr && reg_addr == OFS_CTL && (reg_wdata[CTL_REL] || !reg_wdata[CTL_EN]);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (reset);
    sequence s_rel_wr;
        reg_wr && reg_addr == OFS_CTL && reg_wdata[CTL_REL];
    endsequence
    sequence s_clock_free;
        !scl_oe;
    endsequence
    // ************************************************************
    // Assertions.
    // ************************************************************
    a_rdata_quiet: assert property (!$past(reg_rd) |-> reg_rdata == '0)
        else $error("read data not zero outside its slot");
    a_unmapped_zero: assert property (reg_rd && reg_addr > OFS_BRG |=> reg_rdata == '0)
        else $error("unmapped read not zero");
    a_event_single: assert property (slave_event |=> !slave_event)
        else $error("slave event longer than one cycle");
    a_event_clk_low: assert property (slave_event |-> !scl_in)
        else $error("slave event while bus clock high");
    a_data_stable: assert property (scl_in && $past(scl_in) && !$past(reset) |-> $stable(sda_oe))
        else $error("data line changed while bus clock high");
    a_release_clock: assert property (s_rel_wr ##0 scl_oe |-> ##[1:2] s_clock_free)
        else $error("release write did not free the clock");
    a_hold_cause: assert property ($fell(scl_oe) && !$past(reset) |-> $past(free_wr) || $past(free_wr, 2))
        else $error("clock hold ended without release write");
    a_stretch_low: assert property ($rose(scl_oe) |-> !scl_in)
        else $error("clock hold began while bus clock high");
endmodule : tws_slave_properties
bind tws_slave tws_slave_properties tws_slave_properties_inst (
    .mclk(mclk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .scl_in(scl_in), .scl_out(scl_out), .scl_oe(scl_oe),
    .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe), .slave_event(slave_event)
);
`default_nettype wire

// ==== tws_host.sv ====
// Behavioural bus master that clocks bytes into and out of the slave.
`timescale 1ns/1ns
`default_nettype none
module tws_host (
    input wire logic mclk,
    input wire logic scl,
    input wire logic sda,
    output logic scl_low,
    output logic sda_low
);
    // ************************************************************
    // Bit, byte and framing tasks.
    // ************************************************************
    localparam int HALF = 30;
    initial begin
        scl_low = 1'b0;
        sda_low = 1'b0;
    end
    task automatic pause();
        repeat (HALF) @(posedge mclk);
    endtask : pause
    // Waits while the slave stretches the clock, then samples late in the high phase.
    task automatic clk_bit(input logic b, output logic r);
        sda_low <= !b;
        pause();
        scl_low <= 1'b0;
        for (int i = 0; i < 5000 && scl !== 1'b1; i++) @(posedge mclk);
        pause();
        r = sda;
        scl_low <= 1'b1;
        pause();
    endtask : clk_bit
    task automatic bus_start();
        sda_low <= 1'b0;
        pause();
        scl_low <= 1'b0;
        pause();
        sda_low <= 1'b1;
        pause();
        scl_low <= 1'b1;
        pause();
    endtask : bus_start
    task automatic bus_stop();
        sda_low <= 1'b1;
        pause();
        scl_low <= 1'b0;
        pause();
        sda_low <= 1'b0;
        pause();
    endtask : bus_stop
    task automatic wr_byte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) clk_bit(d[i], r);
        clk_bit(1'b1, r);
        ack = !r;
    endtask : wr_byte
    task automatic rd_byte(input logic ack, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) clk_bit(1'b1, d[i]);
        clk_bit(!ack, r);
    endtask : rd_byte
endmodule : tws_host
`default_nettype wire

// ==== tws_tb.sv ====
// Self-checking testbench for the two-wire bus slave.
`timescale 1ns/1ns
`default_nettype none
module tb
    import tws_pkg::*;
;
    // ************************************************************
    // Signals, clock, instances and run guard.
    // ************************************************************
    logic mclk;
    logic reset = 1'b1;
    logic [REG_AW-1:0] reg_addr = '0;
    logic [REG_DW-1:0] reg_wdata = '0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [REG_DW-1:0] reg_rdata;
    logic scl_out, scl_oe, sda_out, sda_oe, slave_event, m_scl_low, m_sda_low, scl_w, sda_w, ack;
    logic [15:0] st;
    logic [7:0] d8;
    int n_errors = 0;
    int checks_done = 0;
    int n_evt = 0;
    int cyc = 0;
    int e0;
    assign scl_w = !(m_scl_low || (scl_oe === 1'b1 && scl_out !== 1'b1));
    assign sda_w = !(m_sda_low || (sda_oe === 1'b1 && sda_out !== 1'b1));
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    tws_slave tws_slave_inst (.mclk(mclk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .scl_in(scl_w), .scl_out(scl_out),
        .scl_oe(scl_oe), .sda_in(sda_w), .sda_out(sda_out), .sda_oe(sda_oe), .slave_event(slave_event));
    tws_host tws_host_inst (.mclk(mclk), .scl(scl_w), .sda(sda_w), .scl_low(m_scl_low), .sda_low(m_sda_low));
    always @(posedge mclk) begin
        cyc++;
        if (slave_event === 1'b1) n_evt++;
        if (cyc == 60000) begin
            n_errors++;
            report_and_stop();
        end
    end
    // ************************************************************
    // Shared tasks.
    // ************************************************************
    task automatic report_and_stop();
        $display("Checks %0d, errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : report_and_stop
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_errors++;
            $display("Error at %0t ns: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic wr(input logic [REG_AW-1:0] a, input logic [REG_DW-1:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [REG_AW-1:0] a);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        @(negedge mclk);
        st = reg_rdata;
    endtask : rd
    // ************************************************************
    // Scenarios.
    // ************************************************************
    task automatic t_regs();
        rd(OFS_CTL);
        chk(st, CTL_RST);
        wr(OFS_CTL, 16'hffff);
        rd(OFS_CTL);
        chk(st, 16'hffff);
        wr(OFS_STAT, 16'h003f);
        rd(OFS_STAT);
        chk(16'(st[5:0]), 16'h0000);
        wr(OFS_BRG, 16'hffff);
        rd(OFS_BRG);
        chk(st, 16'h01ff);
        wr(OFS_ADDR, 16'hffff);
        rd(OFS_ADDR);
        chk(st, 16'h03ff);
        rd(3'h6);
        chk(st, 16'h0000);
        wr(OFS_BRG, 16'h0004);
        wr(OFS_ADDR, 16'h0352);
        wr(OFS_CTL, 16'h9000);
    endtask : t_regs
    task automatic t_rx7();
        e0 = n_evt;
        tws_host_inst.bus_start();
        tws_host_inst.wr_byte(8'ha4, ack);
        chk(16'(ack), 16'h0001);
        rd(OFS_STAT);
        chk(16'(st[STB_RBF]), 16'h0000);
        tws_host_inst.wr_byte(8'ha5, ack);
        chk(16'(ack), 16'h0001);
        tws_host_inst.wr_byte(8'h3c, ack);
        chk(16'(ack), 16'h0000);
        rd(OFS_RCV);
        chk(st, 16'h00a5);
        rd(OFS_STAT);
        chk(16'(st[STB_OV]), 16'h0001);
        tws_host_inst.wr_byte(8'hc3, ack);
        chk(16'(ack), 16'h0000);
        rd(OFS_RCV);
        chk(st, 16'h00c3);
        wr(OFS_STAT, 16'h0000);
        tws_host_inst.bus_stop();
        chk(16'(n_evt - e0), 16'h0004);
    endtask : t_rx7
    task automatic t_miss();
        e0 = n_evt;
        tws_host_inst.bus_start();
        tws_host_inst.wr_byte(8'ha6, ack);
        chk(16'(ack), 16'h0000);
        tws_host_inst.wr_byte(8'ha4, ack);
        chk(16'(ack), 16'h0000);
        tws_host_inst.bus_stop();
        chk(16'(n_evt - e0), 16'h0000);
    endtask : t_miss
    task automatic t_tx7();
        e0 = n_evt;
        tws_host_inst.bus_start();
        tws_host_inst.wr_byte(8'ha5, ack);
        chk(16'(ack), 16'h0001);
        chk(16'(scl_oe), 16'h0001);
        wr(OFS_TRN, 16'h0096);
        wr(OFS_CTL, 16'h9000);
        tws_host_inst.rd_byte(1'b1, d8);
        chk(16'(d8), 16'h0096);
        chk(16'(scl_oe), 16'h0001);
        wr(OFS_TRN, 16'h005a);
        wr(OFS_CTL, 16'h9000);
        tws_host_inst.rd_byte(1'b0, d8);
        chk(16'(d8), 16'h005a);
        tws_host_inst.bus_stop();
        chk(16'(n_evt - e0), 16'h0003);
    endtask : t_tx7
    task automatic t_ten();
        e0 = n_evt;
        wr(OFS_ADDR, 16'h02b6);
        wr(OFS_CTL, 16'h9400);
        wr(OFS_STAT, 16'h0100);
        tws_host_inst.bus_start();
        tws_host_inst.wr_byte(8'hf4, ack);
        chk(16'(ack), 16'h0001);
        rd(OFS_STAT);
        chk(16'(st[STB_FULL_TEN_BIT_MATCH_FLAG]), 16'h0000);
        tws_host_inst.wr_byte(8'hb6, ack);
        chk(16'(ack), 16'h0001);
        rd(OFS_STAT);
        chk(16'(st[STB_FULL_TEN_BIT_MATCH_FLAG]), 16'h0001);
        tws_host_inst.wr_byte(8'h11, ack);
        chk(16'(ack), 16'h0001);
        rd(OFS_RCV);
        chk(st, 16'h0011);
        tws_host_inst.bus_start();
        tws_host_inst.wr_byte(8'hf5, ack);
        chk(16'(ack), 16'h0001);
        wr(OFS_TRN, 16'h0077);
        wr(OFS_CTL, 16'h9400);
        tws_host_inst.rd_byte(1'b0, d8);
        chk(16'(d8), 16'h0077);
        tws_host_inst.bus_stop();
        chk(16'(n_evt - e0), 16'h0005);
        tws_host_inst.bus_start();
        tws_host_inst.wr_byte(8'hf2, ack);
        chk(16'(ack), 16'h0000);
        tws_host_inst.bus_stop();
    endtask : t_ten
    initial begin
        repeat (12) @(posedge mclk);
        reset <= 1'b0;
        t_regs();
        t_rx7();
        t_miss();
        t_tx7();
        t_ten();
        report_and_stop();
    end
endmodule : tb
`default_nettype wire
